// ===== src/ial_pkg.sv
// What this block does
// - each alarm source has a two-bit route: none, A, B or both.
// - the send alarm rises after the programmed idle seconds; 0 disables.
// - the receive alarm rises after the programmed idle seconds; 0 disables.
// - satellite loopback set to 1 feeds receive input into send output.
// - terrestrial WAN loopback returns send input to receive output.
// - framing loopback does the same on the framing path, independently.
// - port mode decodes 0 off, 1 data, 2 demod out, 3 demod in, 4 switch.
// - port connection decodes auto, 1000, 100 full/half, 10 full/half.
// - VLAN ids 1 to 4094 tag; 0 disables and 4095 is reserved.
// - input buffer occupancy is reported as backlog in milliseconds.
// - send data status shows traffic activity and path health.
`default_nettype none
package ial_pkg;
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned SEC_NS = 1_000_000_000;
	localparam int unsigned CYC_PER_SEC = SEC_NS / CLK_PERIOD_NS;
	localparam int unsigned NUM_PORTS = 5;
	localparam int unsigned IDLE_W = 14;
	localparam logic [13:0] IDLE_MAX = 14'h270F;
	localparam logic [13:0] IDLE_RST = 14'h001E;
	// register byte addresses
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_SND_IDLE = 8'h04;
	localparam logic [7:0] ADR_RCV_IDLE = 8'h08;
	localparam logic [7:0] ADR_BUF_RATE = 8'h0C;
	localparam logic [7:0] ADR_STATUS = 8'h10;
	localparam logic [7:0] ADR_BACKLOG = 8'h14;
	localparam logic [7:0] ADR_IRQ_STAT = 8'h18;
	localparam logic [7:0] ADR_IRQ_CLR = 8'h1C;
	localparam logic [7:0] ADR_IRQ_EN = 8'h20;
	localparam logic [7:0] ADR_PORT0 = 8'h40;
	localparam logic [7:0] PORT_STRIDE = 8'h04;
	// control register fields
	localparam int unsigned CT_RT_LSB = 0;
	localparam int unsigned CT_SAT_LB = 8;
	localparam int unsigned CT_TER_LB = 9;
	localparam int unsigned CT_FRM_LB = 10;
	localparam logic [7:0] CT_RT_RST = 8'h55;
	localparam int unsigned RT_A_BIT = 0;
	localparam int unsigned RT_B_BIT = 1;
	// source order: send, receive, test, hardware
	localparam int unsigned NUM_SRC = 4;
	// port config fields
	localparam int unsigned PC_MODE_LSB = 0;
	localparam int unsigned PC_CONN_LSB = 4;
	localparam int unsigned PC_VLAN_LSB = 16;
	localparam logic [11:0] VLAN_OFF = 12'h000;
	localparam logic [11:0] VLAN_RSVD = 12'hFFF;
	localparam logic [11:0] VLAN_RST = 12'h000;
	typedef enum logic [2:0] {
		MD_OFF = 3'h0, MD_DATA = 3'h1, MD_DMD_OUT = 3'h2,
		MD_DMD_IN = 3'h3, MD_SW_MC = 3'h4
	} ial_mode_e;
	localparam ial_mode_e MODE_RST = MD_DATA;
	typedef enum logic [2:0] {
		CN_AUTO = 3'h0, CN_1000 = 3'h1, CN_100F = 3'h2,
		CN_100H = 3'h3, CN_10F = 3'h4, CN_10H = 3'h5
	} ial_conn_e;
	localparam logic [1:0] SPD_10 = 2'h0;
	localparam logic [1:0] SPD_100 = 2'h1;
	localparam logic [1:0] SPD_1000 = 2'h2;
	typedef enum logic {DV_IDLE = 1'b0, DV_RUN = 1'b1} ial_div_e;
endpackage : ial_pkg
`default_nettype wire

// ===== src/ial_idle_mon.sv
`default_nettype none
module ial_idle_mon (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic tick_sec,
	input wire logic act,
	input wire logic [13:0] limit,
	output logic alarm,
	output logic active
);
	logic [13:0] secs_q;
	logic seen_q;
	logic alarm_q;
	logic active_q;
	wire logic sat = (secs_q == ial_pkg::IDLE_MAX);
	wire logic [13:0] secs_d = act ? 14'h0000 :
		(tick_sec && !sat) ? secs_q + 14'h0001 : secs_q;
	// idle timeout, zero disables
	wire logic alarm_d = (limit != 14'h0000) && (secs_d >= limit);

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			secs_q <= 14'h0000;
			alarm_q <= 1'b0;
		end else begin
			secs_q <= secs_d;
			alarm_q <= alarm_d;
		end
	end

	// activity over the last second
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			seen_q <= 1'b0;
			active_q <= 1'b0;
		end else if (tick_sec) begin
			seen_q <= act;
			active_q <= seen_q | act;
		end else begin
			seen_q <= seen_q | act;
			active_q <= active_q | act;
		end
	end

	assign alarm = alarm_q;
	assign active = active_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	AST_IDLE_DISABLED: assert property (
		(limit == 14'h0000) |=> !alarm
	) else $error("idle alarm raised while disabled");
	AST_IDLE_ACT_CLEARS: assert property (
		act |=> !alarm
	) else $error("idle alarm stays up after activity");
	AST_IDLE_RISE: assert property (
		!act && tick_sec && (limit != 14'h0000)
		&& (secs_q + 14'h0001 == limit) |=> alarm
	) else $error("idle alarm late at limit");
	AST_ACTIVE_SET: assert property (
		act |=> active
	) else $error("activity not shown");
endmodule : ial_idle_mon
`default_nettype wire

// ===== src/ial_ctl.sv
// Decided for this implementation: the plain strobed port and the register addresses.
`default_nettype none
module ial_ctl #(
	parameter int unsigned NPORT = ial_pkg::NUM_PORTS,
	parameter int unsigned DW = 8,
	parameter int unsigned TICKS_PER_SEC = ial_pkg::CYC_PER_SEC
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic snd_act,
	input wire logic rcv_act,
	input wire logic hw_fault_pin,
	input wire logic [15:0] buf_level,
	input wire logic [DW-1:0] ter_snd_data,
	input wire logic ter_snd_vld,
	input wire logic [DW-1:0] sat_rcv_data,
	input wire logic sat_rcv_vld,
	output logic [DW-1:0] mod_snd_data,
	output logic mod_snd_vld,
	output logic [DW-1:0] ter_rcv_data,
	output logic ter_rcv_vld,
	input wire logic [DW-1:0] frm_snd_data,
	input wire logic frm_snd_vld,
	input wire logic [DW-1:0] frm_rcv_in_data,
	input wire logic frm_rcv_in_vld,
	output logic [DW-1:0] frm_rcv_data,
	output logic frm_rcv_vld,
	output logic alarm_a,
	output logic alarm_b,
	output logic irq,
	output logic [3*NPORT-1:0] port_mode,
	output logic [NPORT-1:0] port_en,
	output logic [NPORT-1:0] port_autoneg,
	output logic [2*NPORT-1:0] port_speed,
	output logic [NPORT-1:0] port_full_dplx,
	output logic [NPORT-1:0] vlan_tag_en,
	output logic [12*NPORT-1:0] vlan_id
);
	localparam int unsigned TW = $clog2(TICKS_PER_SEC + 1);
	localparam int unsigned NS = ial_pkg::NUM_SRC;

	function automatic logic [2:0] f_mode(input logic [2:0] m);
		f_mode = (m > ial_pkg::MD_SW_MC) ? ial_pkg::MD_OFF : m;
	endfunction : f_mode

	function automatic logic f_vlan_ok(input logic [11:0] v);
		f_vlan_ok = (v != ial_pkg::VLAN_OFF) && (v != ial_pkg::VLAN_RSVD);
	endfunction : f_vlan_ok

	logic [10:0] ctrl_q;
	logic [13:0] snd_lim_q;
	logic [13:0] rcv_lim_q;
	logic [15:0] rate_q;
	logic [NS-1:0] irq_stat_q;
	logic [NS-1:0] irq_en_q;
	logic [NS-1:0] src_prev_q;
	logic [31:0] rdata_q;
	logic [TW-1:0] tick_cnt_q;
	logic tick_q;
	logic hw_s1_q;
	logic hw_s2_q;
	logic alarm_a_q;
	logic alarm_b_q;
	logic snd_alarm;
	logic rcv_alarm;
	logic snd_active;
	logic rcv_active;
	logic [27:0] pcfg_q [NPORT];

	// write decode
	wire logic wr_ctrl = reg_wr && (reg_addr == ial_pkg::ADR_CTRL);
	wire logic wr_sndl = reg_wr && (reg_addr == ial_pkg::ADR_SND_IDLE);
	wire logic wr_rcvl = reg_wr && (reg_addr == ial_pkg::ADR_RCV_IDLE);
	wire logic wr_rate = reg_wr && (reg_addr == ial_pkg::ADR_BUF_RATE);
	wire logic wr_clr = reg_wr && (reg_addr == ial_pkg::ADR_IRQ_CLR);
	wire logic wr_en = reg_wr && (reg_addr == ial_pkg::ADR_IRQ_EN);
	wire logic [7:0] poff = reg_addr - ial_pkg::ADR_PORT0;
	wire logic [7:0] pidx = poff >> 2;
	wire logic port_hit = (reg_addr >= ial_pkg::ADR_PORT0)
		&& (pidx < 8'(NPORT)) && (poff[1:0] == 2'h0);
	// values above the range clamp to the top
	wire logic [13:0] lim_w = (reg_wdata[31:14] != 18'h00000)
		|| (reg_wdata[13:0] > ial_pkg::IDLE_MAX)
		? ial_pkg::IDLE_MAX : reg_wdata[13:0];

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ctrl_q <= {3'h0, ial_pkg::CT_RT_RST};
			snd_lim_q <= ial_pkg::IDLE_RST;
			rcv_lim_q <= ial_pkg::IDLE_RST;
			rate_q <= 16'h0000;
			irq_en_q <= '0;
		end else begin
			if (wr_ctrl)
				ctrl_q <= reg_wdata[10:0];
			if (wr_sndl)
				snd_lim_q <= lim_w;
			if (wr_rcvl)
				rcv_lim_q <= lim_w;
			if (wr_rate)
				rate_q <= reg_wdata[15:0];
			if (wr_en)
				irq_en_q <= reg_wdata[NS-1:0];
		end
	end

	wire logic sat_lb = ctrl_q[ial_pkg::CT_SAT_LB];
	wire logic ter_lb = ctrl_q[ial_pkg::CT_TER_LB];
	wire logic frm_lb = ctrl_q[ial_pkg::CT_FRM_LB];

	// per-port configuration and decode
	genvar p;
	generate
		for (p = 0; p < NPORT; p++) begin : g_port
			wire logic [2:0] m = pcfg_q[p][ial_pkg::PC_MODE_LSB +: 3];
			wire logic [2:0] c = pcfg_q[p][ial_pkg::PC_CONN_LSB +: 3];
			wire logic [11:0] v = pcfg_q[p][ial_pkg::PC_VLAN_LSB +: 12];
			wire logic hit = port_hit && reg_wr && (pidx == 8'(p));
			always_ff @(posedge sys_clk) begin
				if (sys_rst)
					pcfg_q[p] <= {ial_pkg::VLAN_RST, 9'h000,
						ial_pkg::CN_AUTO, 1'b0, ial_pkg::MODE_RST};
				else if (hit)
					pcfg_q[p] <= {reg_wdata[27:16], 9'h000,
						reg_wdata[6:4], 1'b0, f_mode(reg_wdata[2:0])};
			end
			assign port_mode[3*p +: 3] = m;
			assign port_en[p] = (m != ial_pkg::MD_OFF);
			assign port_autoneg[p] = (c == ial_pkg::CN_AUTO) || (c > ial_pkg::CN_10H);
			assign port_speed[2*p +: 2] =
				(c == ial_pkg::CN_100F || c == ial_pkg::CN_100H)
				? ial_pkg::SPD_100
				: (c == ial_pkg::CN_10F || c == ial_pkg::CN_10H)
				? ial_pkg::SPD_10 : ial_pkg::SPD_1000;
			assign port_full_dplx[p] =
				!(c == ial_pkg::CN_100H || c == ial_pkg::CN_10H);
			assign vlan_tag_en[p] = f_vlan_ok(v);
			assign vlan_id[12*p +: 12] = v;
		end
	endgenerate

	// one-second tick shared by both idle timers
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (tick_cnt_q == TW'(TICKS_PER_SEC - 1));
			tick_cnt_q <= (tick_cnt_q == TW'(TICKS_PER_SEC - 1))
				? '0 : tick_cnt_q + TW'(1);
		end
	end

	ial_idle_mon u_snd_mon (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.tick_sec(tick_q),
		.act(snd_act),
		.limit(snd_lim_q),
		.alarm(snd_alarm),
		.active(snd_active)
	);

	ial_idle_mon u_rcv_mon (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.tick_sec(tick_q),
		.act(rcv_act),
		.limit(rcv_lim_q),
		.alarm(rcv_alarm),
		.active(rcv_active)
	);

	// hardware fault pin is asynchronous
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			hw_s1_q <= 1'b0;
			hw_s2_q <= 1'b0;
		end else begin
			hw_s1_q <= hw_fault_pin;
			hw_s2_q <= hw_s1_q;
		end
	end

	wire logic test_on = sat_lb | ter_lb | frm_lb;
	wire logic [NS-1:0] src = {hw_s2_q, test_on, rcv_alarm, snd_alarm};
	logic [NS-1:0] to_a;
	logic [NS-1:0] to_b;
	genvar s;
	generate
		for (s = 0; s < NS; s++) begin : g_route
			assign to_a[s] = ctrl_q[2*s + ial_pkg::RT_A_BIT];
			assign to_b[s] = ctrl_q[2*s + ial_pkg::RT_B_BIT];
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			alarm_a_q <= 1'b0;
			alarm_b_q <= 1'b0;
		end else begin
			alarm_a_q <= |(src & to_a);
			alarm_b_q <= |(src & to_b);
		end
	end
	assign alarm_a = alarm_a_q;
	assign alarm_b = alarm_b_q;

	// rising alarms are sticky; set beats a same-cycle clear
	wire logic [NS-1:0] evt = src & ~src_prev_q;
	wire logic [NS-1:0] clr = wr_clr ? reg_wdata[NS-1:0] : '0;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			src_prev_q <= '0;
			irq_stat_q <= '0;
		end else begin
			src_prev_q <= src;
			irq_stat_q <= (irq_stat_q & ~clr) | evt;
		end
	end
	assign irq = |(irq_stat_q & irq_en_q);

	// loopback muxes, registered
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			mod_snd_data <= '0;
			mod_snd_vld <= 1'b0;
			ter_rcv_data <= '0;
			ter_rcv_vld <= 1'b0;
			frm_rcv_data <= '0;
			frm_rcv_vld <= 1'b0;
		end else begin
			mod_snd_data <= sat_lb ? sat_rcv_data : ter_snd_data;
			mod_snd_vld <= sat_lb ? sat_rcv_vld : ter_snd_vld;
			ter_rcv_data <= ter_lb ? ter_snd_data : sat_rcv_data;
			ter_rcv_vld <= ter_lb ? ter_snd_vld : sat_rcv_vld;
			frm_rcv_data <= frm_lb ? frm_snd_data : frm_rcv_in_data;
			frm_rcv_vld <= frm_lb ? frm_snd_vld : frm_rcv_in_vld;
		end
	end

	// backlog = level / bytes-per-ms, by repeated subtraction
	// slow but tiny; refresh time scales with the backlog itself
	ial_pkg::ial_div_e dv_q;
	logic [15:0] rem_q;
	logic [15:0] quo_q;
	logic [15:0] backlog_q;
	wire logic sub_ok = (rem_q >= rate_q) && (rate_q != 16'h0000);
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			dv_q <= ial_pkg::DV_IDLE;
			rem_q <= 16'h0000;
			quo_q <= 16'h0000;
			backlog_q <= 16'h0000;
		end else begin
			case (dv_q)
				ial_pkg::DV_IDLE: begin
					rem_q <= buf_level;
					quo_q <= 16'h0000;
					dv_q <= ial_pkg::DV_RUN;
				end
				default: begin
					if (sub_ok) begin
						rem_q <= rem_q - rate_q;
						quo_q <= quo_q + 16'h0001;
					end else begin
						backlog_q <= quo_q;
						dv_q <= ial_pkg::DV_IDLE;
					end
				end
			endcase
		end
	end

	wire logic [7:0] status = {rcv_active, snd_active, alarm_b_q,
		alarm_a_q, hw_s2_q, test_on, rcv_alarm, snd_alarm};
	logic [31:0] rd_d;
	always_comb begin
		rd_d = 32'h0000_0000;
		if (reg_addr == ial_pkg::ADR_CTRL)
			rd_d[10:0] = ctrl_q;
		else if (reg_addr == ial_pkg::ADR_SND_IDLE)
			rd_d[13:0] = snd_lim_q;
		else if (reg_addr == ial_pkg::ADR_RCV_IDLE)
			rd_d[13:0] = rcv_lim_q;
		else if (reg_addr == ial_pkg::ADR_BUF_RATE)
			rd_d[15:0] = rate_q;
		else if (reg_addr == ial_pkg::ADR_STATUS)
			rd_d[7:0] = status;
		else if (reg_addr == ial_pkg::ADR_BACKLOG)
			rd_d[15:0] = backlog_q;
		else if (reg_addr == ial_pkg::ADR_IRQ_STAT)
			rd_d[NS-1:0] = irq_stat_q;
		else if (reg_addr == ial_pkg::ADR_IRQ_EN)
			rd_d[NS-1:0] = irq_en_q;
		else if (port_hit)
			rd_d[27:0] = pcfg_q[pidx[2:0]];
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			rdata_q <= 32'h0000_0000;
		else if (reg_rd)
			rdata_q <= rd_d;
		else
			rdata_q <= 32'h0000_0000;
	end
	assign reg_rdata = rdata_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	AST_SUM_A: assert property (
		snd_alarm && to_a[0] |=> alarm_a
	) else $error("send alarm not routed to A");
	AST_SUM_B_OFF: assert property (
		(src & to_b) == '0 |=> !alarm_b
	) else $error("B raised with no routed source");
	AST_SAT_LB: assert property (
		sat_lb |=> mod_snd_data == $past(sat_rcv_data)
	) else $error("satellite loopback data wrong");
	AST_TER_LB: assert property (
		ter_lb && ter_snd_vld |=> ter_rcv_vld
	) else $error("WAN loopback valid lost");
	AST_FRM_LB: assert property (
		frm_lb |=> frm_rcv_data == $past(frm_snd_data)
	) else $error("framing loopback data wrong");
	AST_MODE_OK: assert property (
		port_mode[2:0] <= ial_pkg::MD_SW_MC
	) else $error("port mode out of range");
	AST_VLAN_RSVD: assert property (
		vlan_id[11:0] == ial_pkg::VLAN_RSVD |-> !vlan_tag_en[0]
	) else $error("reserved vlan tags");
	AST_BACKLOG: assert property (
		dv_q == ial_pkg::DV_RUN && !sub_ok |=> backlog_q == $past(quo_q)
	) else $error("backlog not latched");
	AST_IRQ_SET: assert property (
		evt[0] |=> irq_stat_q[0]
	) else $error("send alarm event lost");
	COV_SND_ALARM: cover property (snd_alarm && alarm_a);
	COV_ALL_LB: cover property (sat_lb && ter_lb && frm_lb);
	COV_IRQ: cover property (irq ##1 wr_clr);
endmodule : ial_ctl
`default_nettype wire

// ===== verif/ial_far_end.sv
`default_nettype none
module ial_far_end (
	input wire logic sys_clk,
	input wire logic snd_en,
	input wire logic rcv_en,
	output logic snd_act,
	output logic rcv_act,
	output logic [7:0] ter_snd_data,
	output logic ter_snd_vld,
	output logic [7:0] sat_rcv_data,
	output logic sat_rcv_vld,
	output logic [7:0] frm_snd_data,
	output logic frm_snd_vld,
	output logic [7:0] frm_rcv_in_data,
	output logic frm_rcv_in_vld
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{snd_act, rcv_act, ter_snd_vld, sat_rcv_vld} = 4'h0;
		{frm_snd_vld, frm_rcv_in_vld} = 2'h0;
		{ter_snd_data, sat_rcv_data, frm_snd_data, frm_rcv_in_data} = 32'h0;
	end
	// data is redrawn every cycle, so a stale word passes for a fresh one only when the random byte repeats
	always @(posedge sys_clk) begin
		{ter_snd_data, sat_rcv_data, frm_snd_data, frm_rcv_in_data} <= $urandom;
		{ter_snd_vld, sat_rcv_vld, frm_snd_vld, frm_rcv_in_vld} <= 4'($urandom);
		snd_act <= snd_en;
		rcv_act <= rcv_en;
	end
endmodule : ial_far_end
`default_nettype wire

// ===== verif/ial_ctl_tb_top.sv
`default_nettype none
module ial_ctl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [11:0] VT [4] = '{12'h000, 12'hFFF, 12'h001, 12'hFFE};
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic hw_fault_pin = 1'b0;
	logic [15:0] buf_level = 16'h0;
	logic snd_en = 1'b1;
	logic rcv_en = 1'b1;
	logic [31:0] reg_rdata, m_r;
	logic snd_act, rcv_act, ter_snd_vld, sat_rcv_vld, frm_snd_vld;
	logic frm_rcv_in_vld, mod_snd_vld, ter_rcv_vld, frm_rcv_vld;
	logic [7:0] ter_snd_data, sat_rcv_data, frm_snd_data, frm_rcv_in_data;
	logic [7:0] mod_snd_data, ter_rcv_data, frm_rcv_data;
	logic alarm_a, alarm_b, irq;
	logic [14:0] port_mode;
	logic [9:0] port_speed;
	logic [4:0] port_en, port_autoneg, port_full_dplx, vlan_tag_en;
	logic [59:0] vlan_id;
	logic [2:0] lb_m = 3'h0;
	logic [8:0] e_mod, e_ter, e_frm;
	logic dp_on = 1'b0;
	logic rd_seen = 1'b0;
	logic [31:0] exp_q[$], msk_q[$];
	int errors = 0;
	int n_compared = 0;
	int cyc = 0;

	ial_ctl #(.TICKS_PER_SEC(10)) u_ial_ctl (
		.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .snd_act, .rcv_act, .hw_fault_pin, .buf_level,
		.ter_snd_data, .ter_snd_vld, .sat_rcv_data, .sat_rcv_vld,
		.mod_snd_data, .mod_snd_vld, .ter_rcv_data, .ter_rcv_vld,
		.frm_snd_data, .frm_snd_vld, .frm_rcv_in_data, .frm_rcv_in_vld,
		.frm_rcv_data, .frm_rcv_vld, .alarm_a, .alarm_b, .irq, .port_mode,
		.port_en, .port_autoneg, .port_speed, .port_full_dplx, .vlan_tag_en,
		.vlan_id
	);
	ial_far_end u_ial_far_end (
		.sys_clk, .snd_en, .rcv_en, .snd_act, .rcv_act, .ter_snd_data,
		.ter_snd_vld, .sat_rcv_data, .sat_rcv_vld, .frm_snd_data,
		.frm_snd_vld, .frm_rcv_in_data, .frm_rcv_in_vld
	);

	initial begin
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic stop_test;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input string n, input logic [31:0] e,
			input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %0h seen %0h", n, e, g);
		end
	endtask : chk

	task automatic dp(input string n, input logic [8:0] e, input logic v,
			input logic [7:0] d);
		chk(n, 32'(e[8]), 32'(v));
		if (e[8] === 1'b1) begin
			chk(n, 32'(e[7:0]), 32'(d));
		end
	endtask : dp

	task automatic hold(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask : hold

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		// the path model switches on the same edge as the register
		if (a == ial_pkg::ADR_CTRL) begin
			lb_m <= d[10:8];
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
			input logic [31:0] m);
		@(posedge sys_clk);
		exp_q.push_back(e);
		msk_q.push_back(m);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
	endtask : rd

	task automatic port_chk(input int p, input logic [2:0] md,
			input logic [2:0] cn, input logic [11:0] vi);
		logic [2:0] m;
		logic [1:0] sp;
		logic t;
		m = (md > 3'h4) ? 3'h0 : md;
		sp = (cn == 3'h4 || cn == 3'h5) ? 2'h0 : 2'h2;
		if (cn == 3'h2 || cn == 3'h3) begin
			sp = 2'h1;
		end
		t = vi != 12'h000 && vi != 12'hFFF;
		chk("mode", 32'(m), 32'(port_mode[3*p+:3]));
		chk("en", 32'(m != 3'h0), 32'(port_en[p]));
		chk("aneg", 32'(cn == 3'h0 || cn > 3'h5), 32'(port_autoneg[p]));
		chk("speed", 32'(sp), 32'(port_speed[2*p+:2]));
		chk("fdx", 32'(cn != 3'h3 && cn != 3'h5), 32'(port_full_dplx[p]));
		chk("tag", 32'(t), 32'(vlan_tag_en[p]));
		if (t) begin
			chk("vid", 32'(vi), 32'(vlan_id[12*p+:12]));
		end
	endtask : port_chk

	always @(posedge sys_clk) begin
		rd_seen <= reg_rd;
		cyc <= cyc + 1;
		e_mod <= lb_m[0] ? {sat_rcv_vld, sat_rcv_data}
			: {ter_snd_vld, ter_snd_data};
		e_ter <= lb_m[1] ? {ter_snd_vld, ter_snd_data}
			: {sat_rcv_vld, sat_rcv_data};
		e_frm <= lb_m[2] ? {frm_snd_vld, frm_snd_data}
			: {frm_rcv_in_vld, frm_rcv_in_data};
		if (cyc == 40000) begin
			errors++;
			stop_test();
		end
	end

	always @(negedge sys_clk) begin
		if (rd_seen) begin
			m_r = msk_q.pop_front();
			chk("reg_rdata", exp_q.pop_front() & m_r, reg_rdata & m_r);
		end else begin
			chk("reg_rdata idle", 32'h0, reg_rdata);
		end
		if (dp_on) begin
			dp("mod_snd", e_mod, mod_snd_vld, mod_snd_data);
			dp("ter_rcv", e_ter, ter_rcv_vld, ter_rcv_data);
			dp("frm_rcv", e_frm, frm_rcv_vld, frm_rcv_data);
		end
	end

	initial begin
		logic [11:0] vi;
		logic [2:0] cn;
		int lv;
		int rt;
		void'($urandom(32'hA004));
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		dp_on <= 1'b1;
		rd(ial_pkg::ADR_CTRL, 32'h55, 32'h7FF);
		rd(ial_pkg::ADR_SND_IDLE, 32'(ial_pkg::IDLE_RST), 32'h3FFF);
		rd(ial_pkg::ADR_RCV_IDLE, 32'(ial_pkg::IDLE_RST), 32'h3FFF);
		rd(8'h3C, 32'h0, 32'hFFFFFFFF);
		hold(0);
		for (int p = 0; p < 5; p++) begin
			port_chk(p, 3'h1, 3'h0, 12'h000);
		end
		// modes 5 to 7 are refused and must read back as off
		for (int i = 0; i < 8; i++) begin
			// codes 6 and 7 are invalid and must fall back to auto
			cn = 3'(7 - i);
			vi = (i < 4) ? VT[i] : 12'($urandom_range(4094, 1));
			wr(ial_pkg::ADR_PORT0 + 8'(i % 5) * ial_pkg::PORT_STRIDE,
				{4'h0, vi, 9'h000, cn, 1'b0, 3'(i)});
			hold(0);
			port_chk(i % 5, 3'(i), cn, vi);
		end
		wr(ial_pkg::ADR_CTRL, 32'h9);
		wr(ial_pkg::ADR_SND_IDLE, 32'h3);
		wr(ial_pkg::ADR_RCV_IDLE, 32'h2);
		@(posedge sys_clk);
		snd_en <= 1'b0;
		rcv_en <= 1'b0;
		hold(12);
		chk("alarm_a early", 32'h0, 32'(alarm_a));
		hold(30);
		chk("alarm_a idle", 32'h1, 32'(alarm_a));
		chk("alarm_b idle", 32'h1, 32'(alarm_b));
		rd(ial_pkg::ADR_STATUS, 32'h33, 32'hFF);
		wr(ial_pkg::ADR_SND_IDLE, 32'h0);
		@(posedge sys_clk);
		rcv_en <= 1'b1;
		hold(5);
		chk("alarm_a off", 32'h0, 32'(alarm_a));
		chk("alarm_b off", 32'h0, 32'(alarm_b));
		@(posedge sys_clk);
		snd_en <= 1'b1;
		wr(ial_pkg::ADR_RCV_IDLE, 32'h2710);
		rd(ial_pkg::ADR_RCV_IDLE, 32'(ial_pkg::IDLE_MAX), 32'h3FFF);
		wr(ial_pkg::ADR_IRQ_EN, 32'h8);
		wr(ial_pkg::ADR_IRQ_CLR, 32'hF);
		for (int r = 0; r < 4; r++) begin
			wr(ial_pkg::ADR_CTRL, 32'(r) << 6);
			@(posedge sys_clk);
			hw_fault_pin <= 1'b1;
			hold(6);
			chk("alarm_a hw", 32'(r & 1), 32'(alarm_a));
			chk("alarm_b hw", 32'(r >> 1), 32'(alarm_b));
			chk("irq", 32'h1, 32'(irq));
			@(posedge sys_clk);
			hw_fault_pin <= 1'b0;
			hold(6);
			chk("alarm_a clr", 32'h0, 32'(alarm_a));
		end
		rd(ial_pkg::ADR_IRQ_STAT, 32'h8, 32'hF);
		wr(ial_pkg::ADR_IRQ_EN, 32'h0);
		hold(1);
		chk("irq masked", 32'h0, 32'(irq));
		wr(ial_pkg::ADR_IRQ_EN, 32'h8);
		hold(1);
		chk("irq unmasked", 32'h1, 32'(irq));
		wr(ial_pkg::ADR_IRQ_CLR, 32'h8);
		hold(1);
		chk("irq cleared", 32'h0, 32'(irq));
		rd(ial_pkg::ADR_IRQ_STAT, 32'h0, 32'hF);
		for (int l = 0; l < 8; l++) begin
			wr(ial_pkg::ADR_CTRL, {21'h0, 3'(l), 8'h30});
			hold(8);
			chk("alarm_a test", 32'(l != 0), 32'(alarm_a));
			chk("alarm_b test", 32'(l != 0), 32'(alarm_b));
			rd(ial_pkg::ADR_STATUS, 32'(l != 0) << 2, 32'h4);
		end
		wr(ial_pkg::ADR_CTRL, 32'h0);
		// a refresh already under way may take up to 2002 cycles
		for (int k = 0; k < 3; k++) begin
			rt = $urandom_range(50, 1);
			lv = $urandom_range(2000, 0);
			wr(ial_pkg::ADR_BUF_RATE, 32'(rt));
			@(posedge sys_clk);
			buf_level <= 16'(lv);
			hold(2100 + lv / rt);
			rd(ial_pkg::ADR_BACKLOG, 32'(lv / rt), 32'hFFFF);
		end
		wr(ial_pkg::ADR_BUF_RATE, 32'h0);
		hold(4);
		rd(ial_pkg::ADR_BACKLOG, 32'h0, 32'hFFFF);
		rd(ial_pkg::ADR_STATUS, 32'hC0, 32'hFF);
		hold(2);
		stop_test();
	end
endmodule : ial_ctl_tb_top
`default_nettype wire
